// File: mbi_cfg.svh
// Purpose: constants for the host bus interface block
// Assumes: 100 MHz system clock, 8-bit host data bus
// Notes: bus type codes select the strobe roles of the control pins
`ifndef MBI_CFG_SVH
`define MBI_CFG_SVH

// Bus type codes
`define MBI_BT_SEP_RDWR 3'h0
`define MBI_BT_PROGRAM_FETCH_STROBE_ONLY 3'h1
`define MBI_BT_E_RW 3'h2
`define MBI_BT_DS_RW 3'h3
`define MBI_BT_SPLIT_LOW 3'h4

// Address decode window, upper address bits 19:12
`define MBI_MEM_BASE 8'h00
`define MBI_MEM_LAST 8'h0F
`define MBI_IO_PAGE 8'h40
// Internal store size in words
`define MBI_MEM_WORDS 256
// Reset value of memory read data
`define MBI_DATA_RST 8'h00

`endif

// File: mbi_pkg.sv
// Purpose: shared types for the host bus interface block
// Assumes: used with mbi_cfg.svh
// Notes: nothing is imported, names are scoped
package mbi_pkg;
    typedef enum logic [2:0] {
        MBI_IDLE = 3'b001,
        MBI_READ = 3'b010,
        MBI_WRITE = 3'b100
    } mbi_state_t;
    typedef logic [19:0] mbi_addr_t;
endpackage

// File: mbi_host_port.sv
// Purpose: slave port between an 8-bit host bus and internal resources
// Assumes: all host pins are sampled through two flip-flops before use
// Notes: one clock domain; strobe edges are detected after synchronisation
`timescale 1ns/1ps
`include "mbi_cfg.svh"

// Overview of operation
// - Multiplexed bus: address on shared port captured when address strobe pulses.
// - Drive shared port only during read strobe with internal resource selected.
// - Latched address bits can be presented on port A or port B.
// - Multiplexed bus: high address bits accepted on ports A, B, C or D.
// - Non-multiplexed bus: address on shared port, data on port A.
// - Non-multiplexed: port A high impedance while host is not accessing.
// - Non-multiplexed: high address bits on ports A, B, C or D.
// - Address strobe optional on non-multiplexed bus; use direct address then.
// - Address bit zero selects even or odd byte; high byte enable ignored.
// - Control pins serve write or R/W, read/E/DS, port D pin strobe.
// - Unused control pin two becomes a logic input; other spare pins reusable.
// - Program-fetch, read and write strobes each qualify internal accesses.
// - Program-fetch strobe alone on control pin one serves all reads.
// - Page mode, multiplexed bus: data on high address pins, timed from low address change.
// - Burst: keep A19-A4 latched, data follows A3-A0 changes.
// - Split mode: latch A11-A4, take A3-A0 directly on port A.
// - Enable clock E with combined read/write line supported.
// - Non-multiplexed: port A pin zero accepted as address bit A16.
module mbi_host_port (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration straps
    input wire logic [2:0] bus_type,
    input wire logic muxed_bus,
    input wire logic page_mode,
    input wire logic use_strobe,
    input wire logic hi_addr_on_a,
    input wire logic a16_on_pa0,
    input wire logic addr_out_a,
    input wire logic addr_out_b,
    input wire logic addr_out_b_high,
    // Host control pins
    input wire logic control_pin_zero,
    input wire logic control_pin_one,
    input wire logic control_pin_two,
    input wire logic port_d_pin_zero,
    input wire logic high_byte_enable,
    // Shared address/data port
    input wire logic [7:0] shared_addr_data_port_i,
    output logic [7:0] shared_addr_data_port_o,
    output logic shared_addr_data_port_oe,
    // Port A
    input wire logic [7:0] port_a_i,
    output logic [7:0] port_a_o,
    output logic port_a_oe,
    // Port B
    input wire logic [7:0] port_b_i,
    output logic [7:0] port_b_o,
    output logic port_b_oe,
    // Ports C and D address inputs
    input wire logic [7:0] port_c_i,
    input wire logic [2:0] port_d_i,
    // I/O page interface
    output logic io_wr,
    output logic [7:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // Status to logic array
    output logic odd_byte,
    output logic spare_logic_in
);

    // Synchroniser stages
    logic [7:0] s1_ad_q, s2_ad_q, s1_pa_q, s2_pa_q, s1_pb_q, s2_pb_q, s1_pc_q, s2_pc_q;
    logic [2:0] s1_pd_q, s2_pd_q;
    logic [4:0] s1_ctl_q, s2_ctl_q;
    logic strb_prev_q;
    logic [7:0] lat_lo_q, lat_hi_q;
    logic [3:0] lat_top_q;
    logic [7:0] rdata_q;
    mbi_pkg::mbi_state_t state_q, state_d;
    logic [7:0] mem_q [0:`MBI_MEM_WORDS-1];

    // Pin synchronisers, two flops before any logic
    always_ff @(posedge clk) begin
        s1_ad_q <= shared_addr_data_port_i;
        s2_ad_q <= s1_ad_q;
        s1_pa_q <= port_a_i;
        s2_pa_q <= s1_pa_q;
        s1_pb_q <= port_b_i;
        s2_pb_q <= s1_pb_q;
        s1_pc_q <= port_c_i;
        s2_pc_q <= s1_pc_q;
        s1_pd_q <= port_d_i;
        s2_pd_q <= s1_pd_q;
        s1_ctl_q <= {high_byte_enable, port_d_pin_zero, control_pin_two, control_pin_one, control_pin_zero};
        s2_ctl_q <= s1_ctl_q;
    end

    // Synchronised control pins
    wire logic c0 = s2_ctl_q[0];
    wire logic c1 = s2_ctl_q[1];
    wire logic c2 = s2_ctl_q[2];
    wire logic strb = s2_ctl_q[3];
    wire logic bt_rw = (bus_type == `MBI_BT_E_RW) || (bus_type == `MBI_BT_DS_RW);
    wire logic bt_psen1 = (bus_type == `MBI_BT_PROGRAM_FETCH_STROBE_ONLY);
    wire logic bt_split = (bus_type == `MBI_BT_SPLIT_LOW);

    // Strobe roles per bus type; active-low strobes on separate-strobe buses
    wire logic rd_act = bt_rw ? (c1 & c0) : (~c1 | (~bt_psen1 & ~c2));
    wire logic wr_act = bt_rw ? (c1 & ~c0) : ~c0;
    // Control pin two free as logic input when no fetch strobe uses it
    assign spare_logic_in = (bt_rw | bt_psen1) ? c2 : 1'b0;

    // Address strobe falling edge ends the address phase
    wire logic strb_fall = use_strobe & strb_prev_q & ~strb;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strb_prev_q <= 1'b0;
        end else begin
            strb_prev_q <= strb;
        end
    end

    // Address latches; strobe only when wired, else direct address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lat_lo_q <= 8'h00;
            lat_hi_q <= 8'h00;
            lat_top_q <= 4'h0;
        end else if (strb_fall) begin
            lat_lo_q <= s2_ad_q;
            lat_hi_q <= s2_pb_q;
            lat_top_q <= hi_addr_on_a ? s2_pa_q[3:0] : s2_pc_q[3:0];
        end
    end

    // Effective address assembly, low nibble follows pins live in burst/split
    // Without a wired strobe the whole low byte comes straight from the pins
    wire logic [7:0] a_lat8 = (muxed_bus & use_strobe) ? lat_lo_q : s2_ad_q;
    wire logic [3:0] a_low4 = bt_split ? s2_pa_q[3:0] : a_lat8[3:0];
    wire logic [7:0] a_low8 = page_mode ? s2_ad_q : {a_lat8[7:4], a_low4};
    wire logic [7:0] a_mid = bt_split ? lat_lo_q : (page_mode ? lat_hi_q : s2_pb_q);
    wire logic [3:0] a_top = use_strobe ? lat_top_q : {1'b0, s2_pd_q};
    wire logic a16 = (a16_on_pa0 & ~muxed_bus) ? s2_pa_q[0] : a_top[0];
    wire mbi_pkg::mbi_addr_t addr = {a_top[3:1], a16, a_mid, a_low8};

    // Resource decode on A19-A12; memory also needs A11-A8 zero
    function automatic logic in_mem(input logic [7:0] hi);
        in_mem = (hi >= `MBI_MEM_BASE) && (hi <= `MBI_MEM_LAST);
    endfunction
    wire logic sel_mem = in_mem(addr[19:12]) && (addr[11:8] == 4'h0);
    wire logic sel_io = (addr[19:12] == `MBI_IO_PAGE);
    wire logic selected = sel_mem | sel_io;

    // Byte lane from address bit zero only
    assign odd_byte = addr[0];

    // Access sequencer
    always_comb begin
        case (state_q)
            mbi_pkg::MBI_IDLE: begin
                if (rd_act && selected) begin
                    state_d = mbi_pkg::MBI_READ;
                end else if (wr_act && selected) begin
                    state_d = mbi_pkg::MBI_WRITE;
                end else begin
                    state_d = mbi_pkg::MBI_IDLE;
                end
            end
            mbi_pkg::MBI_READ: state_d = (rd_act && selected) ? mbi_pkg::MBI_READ : mbi_pkg::MBI_IDLE;
            mbi_pkg::MBI_WRITE: state_d = wr_act ? mbi_pkg::MBI_WRITE : mbi_pkg::MBI_IDLE;
            default: state_d = mbi_pkg::MBI_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= mbi_pkg::MBI_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Write data lane: shared port when muxed, port A otherwise
    wire logic [7:0] wdata = muxed_bus ? s2_ad_q : s2_pa_q;
    wire logic wr_take = (state_q == mbi_pkg::MBI_IDLE) && (state_d == mbi_pkg::MBI_WRITE);

    // Memory write; taken once at strobe start
    always_ff @(posedge clk) begin
        if (wr_take && sel_mem) begin
            mem_q[addr[7:0]] <= wdata;
        end
    end
    assign io_wr = wr_take & sel_io;
    assign io_addr = addr[7:0];
    assign io_wdata = wdata;

    // Read data re-evaluated every cycle so page and burst changes follow
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= `MBI_DATA_RST;
        end else begin
            rdata_q <= sel_io ? io_rdata : mem_q[addr[7:0]];
        end
    end

    // Data drive; page mode on a muxed bus puts data on the high address pins, port B here
    wire logic reading = (state_q == mbi_pkg::MBI_READ) && rd_act && selected;
    wire logic data_on_a = ~muxed_bus;
    wire logic data_on_b = muxed_bus & page_mode;
    assign shared_addr_data_port_o = rdata_q;
    assign shared_addr_data_port_oe = reading & muxed_bus & ~page_mode;

    // Port A: data in non-muxed mode, else optional address out
    wire logic [7:0] a_addr_src = addr[7:0];
    assign port_a_o = data_on_a ? rdata_q : a_addr_src;
    assign port_a_oe = data_on_a ? reading : (addr_out_a & muxed_bus & ~bt_split);

    // Port B: page-mode data or latched address out
    wire logic [7:0] b_addr_src = addr_out_b_high ? addr[15:8] : addr[7:0];
    assign port_b_o = data_on_b ? rdata_q : b_addr_src;
    assign port_b_oe = data_on_b ? reading : addr_out_b;

endmodule

// File: mbi_host_port_sva.sv
// Purpose: port rules of the host bus block as assertions
// Assumes: pins pass two flops, state lags a pin by three edges
// Notes: read and write checks hold only for active-low strobe types
`timescale 1ns/1ps
module mbi_host_port_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Straps and host pins
    input wire logic [2:0] bus_type,
    input wire logic muxed_bus,
    input wire logic control_pin_zero,
    input wire logic control_pin_one,
    input wire logic control_pin_two,
    // Watched outputs
    input wire logic shared_addr_data_port_oe,
    input wire logic port_a_oe,
    input wire logic io_wr,
    input wire logic [7:0] io_addr,
    input wire logic odd_byte,
    input wire logic spare_logic_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Drive only behind a live read strobe
    property p_rd_drive;
        bus_type inside {3'h0, 3'h1} && shared_addr_data_port_oe |-> !$past(control_pin_one, 3);
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("shared port driven without read");
    property p_nonmux_quiet;
        !muxed_bus |-> !shared_addr_data_port_oe;
    endproperty
    a_nonmux_quiet: assert property (p_nonmux_quiet) else $error("shared port driven in non-mux");
    property p_pa_float;
        !muxed_bus && bus_type == 3'h1 && port_a_oe |-> !$past(control_pin_one, 3);
    endproperty
    a_pa_float: assert property (p_pa_float) else $error("port A driven while idle");
    property p_wr_pulse;
        io_wr |=> !io_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("io write longer than a cycle");
    property p_wr_cause;
        bus_type == 3'h0 && io_wr |-> !$past(control_pin_zero, 2);
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("io write without strobe");
    property p_spare_off;
        !(bus_type inside {3'h1, 3'h2, 3'h3}) |-> !spare_logic_in;
    endproperty
    a_spare_off: assert property (p_spare_off) else $error("spare input while pin in use");
    // Spare input follows the synchronised pin once it has settled
    property p_spare_on;
        bus_type inside {3'h1, 3'h2, 3'h3} && $past(control_pin_two, 2) == $past(control_pin_two, 3)
            |-> spare_logic_in == $past(control_pin_two, 2);
    endproperty
    a_spare_on: assert property (p_spare_on) else $error("spare input not following pin");
    property p_odd;
        odd_byte == io_addr[0];
    endproperty
    a_odd: assert property (p_odd) else $error("odd byte not address bit zero");
    // Main scenarios
    c_wr: cover property (io_wr);
    c_rd: cover property (shared_addr_data_port_oe);
    c_pa: cover property (port_a_oe && !muxed_bus);
endmodule
bind mbi_host_port mbi_host_port_sva u_sva (.*);

// File: mbi_host_model.sv
// Purpose: host side of the bus, one access per call
// Assumes: separate active-low strobes, falling-edge driving
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module mbi_host_model (
    // Clock and mode
    input wire logic clk,
    input wire logic muxed_bus,
    // Strobes
    output logic control_pin_zero,
    output logic control_pin_one,
    output logic port_d_pin_zero,
    // Shared port and port A
    output logic [7:0] shared_addr_data_port_i,
    input wire logic [7:0] shared_addr_data_port_o,
    input wire logic shared_addr_data_port_oe,
    output logic [7:0] port_a_i,
    input wire logic [7:0] port_a_o,
    input wire logic port_a_oe
);
    logic [7:0] ad_q = 8'h00;
    logic [7:0] pa_q = 8'h00;
    // Wire level from both parties
    assign shared_addr_data_port_i = shared_addr_data_port_oe ? shared_addr_data_port_o : ad_q;
    assign port_a_i = port_a_oe ? port_a_o : pa_q;
    initial begin
        control_pin_zero = 1'b1;
        control_pin_one = 1'b1;
        port_d_pin_zero = 1'b0;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic oe);
        @(negedge clk);
        ad_q = a;
        if (muxed_bus) begin
            port_d_pin_zero = 1'b1;
            repeat (2) @(negedge clk);
            port_d_pin_zero = 1'b0;
            repeat (2) @(negedge clk);
            ad_q = w ? d : ~a;
        end
        if (!muxed_bus && w)
            pa_q = d;
        if (w)
            control_pin_zero = 1'b0;
        else
            control_pin_one = 1'b0;
        repeat (6) @(negedge clk);
        q = muxed_bus ? shared_addr_data_port_i : port_a_i;
        oe = muxed_bus ? shared_addr_data_port_oe : port_a_oe;
        control_pin_zero = 1'b1;
        control_pin_one = 1'b1;
        // Deassert long enough before the next access
        repeat (4) @(negedge clk);
        ad_q = ~ad_q;
        pa_q = ~pa_q;
    endtask
endmodule

// File: tb_mbi_host_port.sv
// Purpose: self-checking bench for the host bus port
// Assumes: host model drives pins at falling edges
// Notes: the six straps in strap stay at zero; muxed_bus and use_strobe start at one
`timescale 1ns/1ps
module tb_mbi_host_port;
    // Straps and stimulus
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] bus_type = 3'h0;
    logic muxed_bus = 1'b1;
    logic use_strobe = 1'b1;
    logic [5:0] strap = 6'h00;
    logic high_byte_enable = 1'b0;
    logic control_pin_two = 1'b1;
    logic [7:0] port_c_i = 8'h00;
    logic [7:0] wr_seen = 8'h00;
    logic [7:0] q;
    logic oe;
    int miscompares = 0;
    int total_checks = 0;
    // Pins and outputs
    logic control_pin_zero, control_pin_one, port_d_pin_zero, shared_addr_data_port_oe, port_a_oe, port_b_oe;
    logic io_wr, odd_byte, spare_logic_in;
    logic [7:0] shared_addr_data_port_i, shared_addr_data_port_o, port_a_i, port_a_o, port_b_o, io_addr, io_wdata;
    mbi_host_port u_mbi_host_port (.clk, .sys_rst, .bus_type, .muxed_bus, .page_mode(strap[0]), .use_strobe,
        .hi_addr_on_a(strap[1]), .a16_on_pa0(strap[2]), .addr_out_a(strap[3]), .addr_out_b(strap[4]),
        .addr_out_b_high(strap[5]), .control_pin_zero, .control_pin_one, .control_pin_two, .port_d_pin_zero,
        .high_byte_enable, .shared_addr_data_port_i, .shared_addr_data_port_o, .shared_addr_data_port_oe,
        .port_a_i, .port_a_o, .port_a_oe, .port_b_i(8'h00), .port_b_o, .port_b_oe, .port_c_i, .port_d_i(3'h0),
        .io_wr, .io_addr, .io_wdata, .io_rdata(8'h00), .odd_byte, .spare_logic_in);
    mbi_host_model u_mbi_host_model (.clk, .muxed_bus, .control_pin_zero, .control_pin_one, .port_d_pin_zero,
        .shared_addr_data_port_i, .shared_addr_data_port_o, .shared_addr_data_port_oe, .port_a_i, .port_a_o,
        .port_a_oe);
    initial forever #5 clk = ~clk;
    // Capture io writes, the pulse is one cycle
    always @(posedge clk) if (io_wr === 1'b1) wr_seen <= io_wdata;
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic t_mux();
        u_mbi_host_model.acc(1'b1, 8'h03, 8'h5a, q, oe);
        u_mbi_host_model.acc(1'b1, 8'h02, 8'ha5, q, oe);
        high_byte_enable = 1'b1;
        u_mbi_host_model.acc(1'b0, 8'h03, 8'h00, q, oe);
        chk(oe === 1'b1 && q === 8'h5a, "odd byte read");
        chk(odd_byte === 1'b1, "odd lane flag");
        u_mbi_host_model.acc(1'b0, 8'h02, 8'h00, q, oe);
        chk(oe === 1'b1 && q === 8'ha5, "even byte read");
        chk(odd_byte === 1'b0, "even lane flag");
        $display("test mux done");
    endtask
    task automatic t_unsel();
        port_c_i = 8'h01;
        u_mbi_host_model.acc(1'b1, 8'h03, 8'hff, q, oe);
        u_mbi_host_model.acc(1'b0, 8'h03, 8'h00, q, oe);
        chk(oe === 1'b0, "unselected read driven");
        port_c_i = 8'h04;
        u_mbi_host_model.acc(1'b1, 8'h07, 8'hc3, q, oe);
        chk(wr_seen === 8'hc3, "io page write");
        chk(io_addr === 8'h07, "io page address");
        port_c_i = 8'h00;
        u_mbi_host_model.acc(1'b0, 8'h03, 8'h00, q, oe);
        chk(q === 8'h5a, "unselected write changed memory");
        $display("test unselected done");
    endtask
    task automatic t_nonmux();
        muxed_bus = 1'b0;
        use_strobe = 1'b0;
        bus_type = 3'h1;
        u_mbi_host_model.acc(1'b1, 8'h10, 8'h3c, q, oe);
        u_mbi_host_model.acc(1'b0, 8'h10, 8'h00, q, oe);
        chk(oe === 1'b1 && q === 8'h3c, "port A read");
        chk(port_a_oe === 1'b0 && shared_addr_data_port_oe === 1'b0, "port A left driven");
        $display("test nonmux done");
    endtask
    task automatic t_spare();
        control_pin_two = 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus_type = i[2:0];
            repeat (5) @(negedge clk);
            chk(spare_logic_in === (i inside {1, 2, 3}), "spare input");
        end
        $display("test spare done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        t_mux();
        t_unsel();
        t_nonmux();
        t_spare();
        results();
    end
    // Cut a hang short
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        $display("mismatch at %0t: run timed out", $time);
        results();
    end
endmodule
